// *** bench/tb_rtccal_regs.sv ***
`timescale 1ns/10ps
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin n_mismatch++; \
   $display("unexpected at %0t: got %h expected %h", $time, got, exp); end end

module tb_rtccal_regs
   import rtccal_pkg::*;
;
   //===========================================================================
   // signals
   //===========================================================================
   localparam logic [DATA_W-1:0] KEY0 = 32'h0badf00d; // arbitrary value
   localparam logic [DATA_W-1:0] KEY1 = 32'h600dcafe; // arbitrary value

   typedef struct {
      logic [ADDR_W-1:0] a;
      logic [DATA_W-1:0] w;
      logic [DATA_W-1:0] r;
   } rtccal_row_t;

   logic              mclk     = 1'b0;
   logic              rst_n    = 1'b0;
   rtccal_bus_t       bus      = '0;
   logic [DATA_W-1:0] rd_data;
   logic              sec_tick = 1'b0;
   logic [ASEC_W-1:0] cur_sec  = '0;
   rtccal_cal_t       cal;
   logic              unlocked;
   logic              irq;
   int                n_mismatch = 0;
   int                n_checks   = 0;
   logic [DATA_W-1:0] d;
   logic [ADDR_W-1:0] addrs [5] = '{OFS_MDAY, OFS_MON, OFS_YEAR, OFS_WDAY, OFS_ASEC};
   logic [DATA_W-1:0] rstv  [5] = '{32'h1, 32'h0, 32'h0, 32'h0, 32'h0};
   rtccal_row_t       rows  [10] = '{
      '{OFS_MDAY, 32'hffffffff, 32'h3f}, '{OFS_MON,  32'hffffffff, 32'h1f},
      '{OFS_YEAR, 32'hffffffff, 32'hff}, '{OFS_WDAY, 32'hffffffff, 32'h07},
      '{OFS_ASEC, 32'hffffffff, 32'h7f}, '{OFS_MDAY, 32'h00000031, 32'h31},
      '{OFS_MON,  32'h00000012, 32'h12}, '{OFS_YEAR, 32'h00000099, 32'h99},
      '{OFS_WDAY, 32'h00000006, 32'h06}, '{OFS_ASEC, 32'h00000059, 32'h59}};
   localparam logic [28:0] CAL_RST = {RST_MDAY, RST_MON, RST_YEAR, RST_WDAY, RST_ASEC};

   always #25 mclk = ~mclk;

   rtccal_regs #(
      .UNLOCK_KEY0 (KEY0),
      .UNLOCK_KEY1 (KEY1)
   ) DUT (
      .mclk     (mclk),
      .rst_n    (rst_n),
      .bus      (bus),
      .rd_data  (rd_data),
      .sec_tick (sec_tick),
      .cur_sec  (cur_sec),
      .cal      (cal),
      .unlocked (unlocked),
      .irq      (irq)
   );

   //===========================================================================
   // bus and helper tasks
   //===========================================================================
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] w);
      @(posedge mclk);
      bus <= '{addr: a, wdata: w, wr: 1'b1, rd: 1'b0};
      @(posedge mclk);
      bus.wr <= 1'b0;
      #1;
   endtask

   task automatic chk_rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
      @(posedge mclk);
      bus <= '{addr: a, wdata: '0, wr: 1'b0, rd: 1'b1};
      @(posedge mclk);
      bus.rd <= 1'b0;
      #1 d = rd_data;
      `CHK(d, e)
   endtask

   task automatic tick(input logic [ASEC_W-1:0] s);
      @(posedge mclk);
      sec_tick <= 1'b1;
      cur_sec  <= s;
      @(posedge mclk);
      sec_tick <= 1'b0;
      repeat (2) @(posedge mclk);
      #1;
   endtask

   function automatic logic [DATA_W-1:0] field_of(input logic [ADDR_W-1:0] a);
      case (a)
         OFS_MDAY: return 32'(cal.mday);
         OFS_MON:  return 32'(cal.mon);
         OFS_YEAR: return 32'(cal.year);
         OFS_WDAY: return 32'(cal.wday);
         default:  return 32'(cal.asec);
      endcase
   endfunction

   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   //===========================================================================
   // tests
   //===========================================================================
   initial begin
      repeat (2) @(posedge mclk);
      rst_n <= 1'b1;
      #1;
      // ordinary field cases come after unlocking, so reset and lock go first
      `CHK(cal, CAL_RST)
      `CHK({unlocked, irq}, 2'h0)
      for (int i = 0; i < 5; i++) chk_rd(addrs[i], rstv[i]);
      chk_rd(8'h04, 32'h0);
      $display("test reset done");
      wr(OFS_IRQ_MASK, 32'hfffffffe);
      chk_rd(OFS_IRQ_MASK, 32'h2);
      for (int i = 0; i < 5; i++) wr(addrs[i], 32'h5);
      `CHK(cal, CAL_RST)
      `CHK(irq, 1'b1)
      chk_rd(OFS_IRQ_STAT, 32'h2);
      chk_rd(OFS_IRQ_STAT, 32'h0);
      `CHK(irq, 1'b0)
      $display("test locked done");
      wr(OFS_KEY0, KEY0);
      `CHK(unlocked, 1'b0)
      chk_rd(OFS_LOCK_STAT, 32'h1);
      wr(OFS_KEY1, KEY1);
      `CHK(unlocked, 1'b1)
      chk_rd(OFS_LOCK_STAT, 32'h3);
      foreach (rows[i]) begin
         wr(rows[i].a, rows[i].w);
         chk_rd(rows[i].a, rows[i].r);
         `CHK(field_of(rows[i].a), rows[i].r)
      end
      $display("test fields done");
      wr(OFS_IRQ_MASK, 32'h1);
      tick(7'h58);
      `CHK(irq, 1'b0)
      tick(7'h59);
      `CHK(irq, 1'b1)
      chk_rd(OFS_IRQ_STAT, 32'h1);
      `CHK(irq, 1'b0)
      // alarm event in the same cycle as the status read: the event wins
      fork
         tick(7'h59);
         begin
            @(posedge mclk);
            chk_rd(OFS_IRQ_STAT, 32'h0);
         end
      join
      `CHK(irq, 1'b1)
      chk_rd(OFS_IRQ_STAT, 32'h1);
      `CHK(irq, 1'b0)
      $display("test alarm done");
      wr(OFS_KEY0, ~KEY0);
      `CHK(unlocked, 1'b0)
      chk_rd(OFS_LOCK_STAT, 32'h0);
      wr(OFS_KEY1, KEY1);
      `CHK(unlocked, 1'b0)
      wr(OFS_MDAY, 32'h12);
      chk_rd(OFS_MDAY, 32'h31);
      @(posedge mclk);
      rst_n <= 1'b0;
      repeat (2) @(posedge mclk);
      rst_n <= 1'b1;
      #1;
      `CHK(cal, CAL_RST)
      `CHK(unlocked, 1'b0)
      `CHK(irq, 1'b0)
      wr(OFS_MDAY, 32'h12);
      chk_rd(OFS_MDAY, 32'h1);
      $display("test relock done");
      report_and_stop;
   end

   initial begin
      #50000;
      n_mismatch++;
      $display("unexpected at %0t: watchdog expired", $time);
      report_and_stop;
   end

endmodule // tb_rtccal_regs

// *** src/rtccal_alarm_match.sv ***
`timescale 1ns/10ps
//==============================================================================
// alarm seconds compare
//==============================================================================
module rtccal_alarm_match
   import rtccal_pkg::*;
(
   // clock and reset
   input  wire logic              mclk,
   input  wire logic              rst_n,
   // time base
   input  wire logic              sec_tick,
   input  wire logic [ASEC_W-1:0] cur_sec,
   input  wire logic [ASEC_W-1:0] alarm_sec,
   // result
   output logic                   hit
);
   wire match = sec_tick && (cur_sec == alarm_sec);

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         hit <= 1'b0;
      end else begin
         hit <= match;
      end
   end
endmodule // rtccal_alarm_match

// *** src/rtccal_pkg.sv ***
//==============================================================================
// calendar and alarm-second register package
//==============================================================================
// Overview of operation
// - day of month held as tens digit in bits 5-4, units in 3-0, range 01-31.
// - month held as tens bit 4 and units digit bits 3-0, January 01.
// - year held as tens digit bits 7-4, units digit bits 3-0, 00-99.
// - weekday held in bits 2-0, Sunday 0 through Saturday 6h.
// - alarm seconds held as tens bits 6-4 and units bits 3-0, 00-59.
// - stored alarm seconds is the seconds value that raises the alarm interrupt.
// - each decimal digit is stored as the plain binary value of that digit.
// - after reset the calendar and alarm-second registers refuse writes until both unlock keys are written; the interrupt mask does not.
// - reset loads day 01; year, weekday and alarm seconds load zero.
package rtccal_pkg;

   //===========================================================================
   // register offsets (byte addresses)
   //===========================================================================
   localparam int         ADDR_W        = 8;
   localparam int         DATA_W        = 32;
   localparam logic [7:0] OFS_MDAY      = 8'h0c;
   localparam logic [7:0] OFS_MON       = 8'h10;
   localparam logic [7:0] OFS_YEAR      = 8'h14;
   localparam logic [7:0] OFS_WDAY      = 8'h18;
   localparam logic [7:0] OFS_ASEC      = 8'h20;
   localparam logic [7:0] OFS_KEY0      = 8'h6c;
   localparam logic [7:0] OFS_KEY1      = 8'h70;
   localparam logic [7:0] OFS_LOCK_STAT = 8'h74;
   localparam logic [7:0] OFS_IRQ_STAT  = 8'h78;
   localparam logic [7:0] OFS_IRQ_MASK  = 8'h7c;

   //===========================================================================
   // field widths and positions
   //===========================================================================
   localparam int MDAY_W     = 6;
   localparam int MON_W      = 5;
   localparam int YEAR_W     = 8;
   localparam int WDAY_W     = 3;
   localparam int ASEC_W     = 7;
   localparam int UNITS_LSB  = 0;
   localparam int TENS_LSB   = 4;

   //===========================================================================
   // reset values
   //===========================================================================
   localparam logic [5:0] RST_MDAY = 6'h01;
   localparam logic [4:0] RST_MON  = 5'h00;
   localparam logic [7:0] RST_YEAR = 8'h00;
   localparam logic [2:0] RST_WDAY = 3'h0;
   localparam logic [6:0] RST_ASEC = 7'h00;

   //===========================================================================
   // interrupt status bits
   //===========================================================================
   localparam int IRQ_W     = 2;
   localparam int IRQ_ALARM = 0;
   localparam int IRQ_DENY  = 1;
   localparam logic [IRQ_W-1:0] RST_IRQ = 2'h0;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic              wr;
      logic              rd;
   } rtccal_bus_t;

   typedef struct packed {
      logic [MDAY_W-1:0] mday;
      logic [MON_W-1:0]  mon;
      logic [YEAR_W-1:0] year;
      logic [WDAY_W-1:0] wday;
      logic [ASEC_W-1:0] asec;
   } rtccal_cal_t;

endpackage

// *** src/rtccal_regs.sv ***
// The register addresses and the strobed register port were left to the implementer.
`timescale 1ns/10ps
//==============================================================================
// calendar and alarm-second registers
//==============================================================================
module rtccal_regs
   import rtccal_pkg::*;
#(
   parameter logic [DATA_W-1:0] UNLOCK_KEY0 = 32'h11223344, // arbitrary value
   parameter logic [DATA_W-1:0] UNLOCK_KEY1 = 32'h55667788  // arbitrary value
)
(
   // clock and reset
   input  wire logic              mclk,
   input  wire logic              rst_n,
   // register port
   input  wire rtccal_bus_t       bus,
   output logic [DATA_W-1:0]      rd_data,
   // seconds time base from the clock counter
   input  wire logic              sec_tick,
   input  wire logic [ASEC_W-1:0] cur_sec,
   // calendar state and interrupt
   output rtccal_cal_t            cal,
   output logic                   unlocked,
   output logic                   irq
);

   //===========================================================================
   // state
   //===========================================================================
   rtccal_cal_t       cal_reg;
   rtccal_cal_t       cal_next;
   logic              key0_ok_reg;
   logic              key0_ok_next;
   logic              unlock_reg;
   logic              unlock_next;
   logic [IRQ_W-1:0]  stat_reg;
   logic [IRQ_W-1:0]  stat_next;
   logic [IRQ_W-1:0]  mask_reg;
   logic [IRQ_W-1:0]  mask_next;
   logic [DATA_W-1:0] rd_data_reg;
   logic [DATA_W-1:0] rd_data_next;
   logic              alarm_hit;

   function automatic logic [DATA_W-1:0] zext(input logic [7:0] v);
      return {24'h000000, v};
   endfunction

   //===========================================================================
   // address decode
   //===========================================================================
   wire sel_mday  = (bus.addr == OFS_MDAY);
   wire sel_mon   = (bus.addr == OFS_MON);
   wire sel_year  = (bus.addr == OFS_YEAR);
   wire sel_wday  = (bus.addr == OFS_WDAY);
   wire sel_asec  = (bus.addr == OFS_ASEC);
   wire sel_key0  = (bus.addr == OFS_KEY0);
   wire sel_key1  = (bus.addr == OFS_KEY1);
   wire sel_lock  = (bus.addr == OFS_LOCK_STAT);
   wire sel_stat  = (bus.addr == OFS_IRQ_STAT);
   wire sel_mask  = (bus.addr == OFS_IRQ_MASK);
   wire sel_cal   = sel_mday | sel_mon | sel_year | sel_wday | sel_asec;

   // protected writes only land once unlocked
   wire wr_ok     = bus.wr && unlock_reg;
   wire wr_denied = bus.wr && !unlock_reg && sel_cal;

   //===========================================================================
   // calendar fields, digits kept as plain binary
   //===========================================================================
   assign cal_next.mday = (wr_ok && sel_mday) ? bus.wdata[MDAY_W-1:0]
                                              : cal_reg.mday;
   assign cal_next.mon  = (wr_ok && sel_mon)  ? bus.wdata[MON_W-1:0]
                                              : cal_reg.mon;
   assign cal_next.year = (wr_ok && sel_year) ? bus.wdata[YEAR_W-1:0]
                                              : cal_reg.year;
   assign cal_next.wday = (wr_ok && sel_wday) ? bus.wdata[WDAY_W-1:0]
                                              : cal_reg.wday;
   assign cal_next.asec = (wr_ok && sel_asec) ? bus.wdata[ASEC_W-1:0]
                                              : cal_reg.asec;

   //===========================================================================
   // unlock key sequence: key0 then key1, a wrong key relocks
   //===========================================================================
   wire key0_good = bus.wr && sel_key0 && (bus.wdata == UNLOCK_KEY0);
   wire key1_good = bus.wr && sel_key1 && (bus.wdata == UNLOCK_KEY1) && key0_ok_reg;
   wire key_bad   = bus.wr && ((sel_key0 && !key0_good) || (sel_key1 && !key1_good));

   assign key0_ok_next = key_bad ? 1'b0 : (key0_good ? 1'b1 : key0_ok_reg);
   assign unlock_next  = key_bad ? 1'b0 : (key1_good ? 1'b1 : unlock_reg);

   //===========================================================================
   // interrupt status: read clears, a new event wins over the clear
   //===========================================================================
   wire [IRQ_W-1:0] irq_events = {wr_denied, alarm_hit};
   wire             stat_rd    = bus.rd && sel_stat;

   assign stat_next = (stat_rd ? RST_IRQ : stat_reg) | irq_events;
   assign mask_next = (bus.wr && sel_mask) ? bus.wdata[IRQ_W-1:0] : mask_reg;
   assign irq       = |(stat_reg & mask_reg);

   //===========================================================================
   // read mux, unused upper bits read zero
   //===========================================================================
   wire [DATA_W-1:0] rd_mux =
      sel_mday ? zext({2'b00, cal_reg.mday}) :
      sel_mon  ? zext({3'b000, cal_reg.mon}) :
      sel_year ? zext(cal_reg.year) :
      sel_wday ? zext({5'b00000, cal_reg.wday}) :
      sel_asec ? zext({1'b0, cal_reg.asec}) :
      sel_lock ? zext({6'b000000, unlock_reg, key0_ok_reg}) :
      sel_stat ? zext({6'b000000, stat_reg}) :
      sel_mask ? zext({6'b000000, mask_reg}) :
      32'h00000000;

   assign rd_data_next = bus.rd ? rd_mux : 32'h00000000;

   //===========================================================================
   // alarm compare
   //===========================================================================
   rtccal_alarm_match u_alarm (
      .mclk      (mclk),
      .rst_n     (rst_n),
      .sec_tick  (sec_tick),
      .cur_sec   (cur_sec),
      .alarm_sec (cal_reg.asec),
      .hit       (alarm_hit)
   );

   //===========================================================================
   // flops
   //===========================================================================
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         cal_reg <= '{mday: RST_MDAY, mon: RST_MON, year: RST_YEAR,
                      wday: RST_WDAY, asec: RST_ASEC};
      end else begin
         cal_reg <= cal_next;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         key0_ok_reg <= 1'b0;
      end else begin
         key0_ok_reg <= key0_ok_next;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         unlock_reg <= 1'b0;
      end else begin
         unlock_reg <= unlock_next;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         stat_reg <= RST_IRQ;
      end else begin
         stat_reg <= stat_next;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         mask_reg <= RST_IRQ;
      end else begin
         mask_reg <= mask_next;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         rd_data_reg <= 32'h00000000;
      end else begin
         rd_data_reg <= rd_data_next;
      end
   end

   assign cal      = cal_reg;
   assign unlocked = unlock_reg;
   assign rd_data  = rd_data_reg;

   //===========================================================================
   // checks
   //===========================================================================
   a_locked_write_held: assert property (@(posedge mclk) disable iff (!rst_n)
      (bus.wr && !unlock_reg && sel_cal) |=> $stable(cal_reg))
      else $error("calendar changed on a locked write");

   a_locked_flags_deny: assert property (@(posedge mclk) disable iff (!rst_n)
      (bus.wr && !unlock_reg && sel_cal) |=> stat_reg[IRQ_DENY])
      else $error("locked write did not flag denial");

   a_mday_write_taken: assert property (@(posedge mclk) disable iff (!rst_n)
      (bus.wr && unlock_reg && sel_mday) |=> cal_reg.mday == $past(bus.wdata[5:0]))
      else $error("day of month write lost");

   a_mon_write_taken: assert property (@(posedge mclk) disable iff (!rst_n)
      (bus.wr && unlock_reg && sel_mon) |=> cal_reg.mon == $past(bus.wdata[4:0]))
      else $error("month write lost");

   a_year_write_taken: assert property (@(posedge mclk) disable iff (!rst_n)
      (bus.wr && unlock_reg && sel_year) |=> cal_reg.year == $past(bus.wdata[7:0]))
      else $error("year write lost");

   a_wday_write_taken: assert property (@(posedge mclk) disable iff (!rst_n)
      (bus.wr && unlock_reg && sel_wday) |=> cal_reg.wday == $past(bus.wdata[2:0]))
      else $error("weekday write lost");

   a_asec_write_taken: assert property (@(posedge mclk) disable iff (!rst_n)
      (bus.wr && unlock_reg && sel_asec) |=> cal_reg.asec == $past(bus.wdata[6:0]))
      else $error("alarm seconds write lost");

   a_alarm_sets_status: assert property (@(posedge mclk) disable iff (!rst_n)
      (sec_tick && cur_sec == cal_reg.asec && !(bus.wr && sel_asec)) |-> ##2 stat_reg[IRQ_ALARM])
      else $error("alarm match did not set status");

   a_reserved_read_zero: assert property (@(posedge mclk) disable iff (!rst_n)
      (bus.rd && sel_mday) |=> (rd_data[31:6] == 26'h0))
      else $error("reserved day bits not zero");

   a_unlock_needs_keys: assert property (@(posedge mclk) disable iff (!rst_n)
      $rose(unlock_reg) |-> $past(bus.wr && sel_key1 && key0_ok_reg))
      else $error("unlocked without key sequence");

   //===========================================================================
   // read path, key sequence, reset and status checks
   //===========================================================================
   a_mon_reserved_zero: assert property (@(posedge mclk) disable iff (!rst_n)
      (bus.rd && sel_mon) |=> (rd_data[31:5] == 27'h0))
      else $error("reserved month bits not zero");

   a_year_reserved_zero: assert property (@(posedge mclk) disable iff (!rst_n)
      (bus.rd && sel_year) |=> (rd_data[31:8] == 24'h0))
      else $error("reserved year bits not zero");

   a_wday_reserved_zero: assert property (@(posedge mclk) disable iff (!rst_n)
      (bus.rd && sel_wday) |=> (rd_data[31:3] == 29'h0))
      else $error("reserved weekday bits not zero");

   a_asec_reserved_zero: assert property (@(posedge mclk) disable iff (!rst_n)
      (bus.rd && sel_asec) |=> (rd_data[31:7] == 25'h0))
      else $error("reserved alarm seconds bits not zero");

   a_mday_read_back: assert property (@(posedge mclk) disable iff (!rst_n)
      (bus.rd && sel_mday) |=> (rd_data[5:0] == $past(cal_reg.mday)))
      else $error("day of month read wrong");

   a_mon_read_back: assert property (@(posedge mclk) disable iff (!rst_n)
      (bus.rd && sel_mon) |=> (rd_data[4:0] == $past(cal_reg.mon)))
      else $error("month read wrong");

   a_year_read_back: assert property (@(posedge mclk) disable iff (!rst_n)
      (bus.rd && sel_year) |=> (rd_data[7:0] == $past(cal_reg.year)))
      else $error("year read wrong");

   a_wday_read_back: assert property (@(posedge mclk) disable iff (!rst_n)
      (bus.rd && sel_wday) |=> (rd_data[2:0] == $past(cal_reg.wday)))
      else $error("weekday read wrong");

   a_asec_read_back: assert property (@(posedge mclk) disable iff (!rst_n)
      (bus.rd && sel_asec) |=> (rd_data[6:0] == $past(cal_reg.asec)))
      else $error("alarm seconds read wrong");

   a_read_idle_zero: assert property (@(posedge mclk) disable iff (!rst_n)
      !bus.rd |=> (rd_data == 32'h00000000))
      else $error("read data not zero outside a read");

   a_lock_read_back: assert property (@(posedge mclk) disable iff (!rst_n)
      (bus.rd && sel_lock) |=> (rd_data[1:0] == $past({unlock_reg, key0_ok_reg})))
      else $error("lock status read wrong");

   a_key0_alone_locked: assert property (@(posedge mclk) disable iff (!rst_n)
      (!unlock_reg && bus.wr && sel_key0) |=> !unlock_reg)
      else $error("first key alone unlocked");

   a_key1_needs_key0: assert property (@(posedge mclk) disable iff (!rst_n)
      (!key0_ok_reg && !unlock_reg && bus.wr && sel_key1) |=> !unlock_reg)
      else $error("second key unlocked without first");

   a_bad_key_relocks: assert property (@(posedge mclk) disable iff (!rst_n)
      (bus.wr && sel_key0 && (bus.wdata != UNLOCK_KEY0)) |=> (!unlock_reg && !key0_ok_reg))
      else $error("wrong key did not relock");

   a_unlock_held: assert property (@(posedge mclk) disable iff (!rst_n)
      (unlock_reg && !(bus.wr && (sel_key0 || sel_key1))) |=> unlock_reg)
      else $error("lock closed without a key write");

   a_reset_values: assert property (@(posedge mclk) disable iff (!rst_n)
      $rose(rst_n) |-> ((cal_reg == {RST_MDAY, RST_MON, RST_YEAR, RST_WDAY, RST_ASEC})
                        && !unlock_reg))
      else $error("wrong state after reset");

   a_status_read_clears: assert property (@(posedge mclk) disable iff (!rst_n)
      (bus.rd && !bus.wr && sel_stat && !alarm_hit) |=> (stat_reg == RST_IRQ))
      else $error("status read did not clear");

   a_event_beats_clear: assert property (@(posedge mclk) disable iff (!rst_n)
      (bus.rd && sel_stat && alarm_hit) |=> stat_reg[IRQ_ALARM])
      else $error("alarm lost to a status read");

   a_unlocked_no_deny: assert property (@(posedge mclk) disable iff (!rst_n)
      (bus.wr && unlock_reg) |=> !$rose(stat_reg[IRQ_DENY]))
      else $error("denial flagged while unlocked");

endmodule // rtccal_regs
